//--- rtl/kpc_config_bank.sv
/*
 * configuration register bank of the key-matrix controller: debounce and
 * output select, alert trigger, output pin levels and key repeat control.
 * assumes the serial slave presents one-cycle read/write strobes with an
 * 8-bit register address, and that scan logic reports key events and fifo level.
 *
 */
`timescale 1ns/1ps
`default_nettype none
module kpc_config_bank
    import kpc_pkg::*;
#(
    parameter int unsigned  MS_COUNT = MS_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire kpc_reg_req_type    regReq,
    output logic [7:0]              regRdata,
    input  wire kpc_key_status_type keyStatus,
    output logic [5:0]              portOutEn,
    output logic [5:0]              portOut,
    output logic [5:0]              portScanEn,
    output logic                    alertOut,
    output logic                    alertOutEn,
    output logic                    repeatPush,
    output logic [7:0]              repeatCode,
    output logic                    repeatActive,
    output logic                    debounceTick,
    output logic [4:0]              debounceCode
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] debounce_q;
    logic [7:0] alert_q;
    logic [7:0] levels_q;
    logic [7:0] repeat_q;
    logic       debTick;
    logic       repPush;
    logic       repActive;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            debounce_q <= RST_DEBOUNCE;
            alert_q    <= RST_ALERT;
            levels_q   <= RST_LEVELS;
            repeat_q   <= RST_REPEAT;
        end else if (regReq.write) begin
            if (regReq.addr == ADDR_DEBOUNCE) begin
                debounce_q <= regReq.wdata;
            end else if (regReq.addr == ADDR_ALERT) begin
                alert_q <= regReq.wdata;
            end else if (regReq.addr == ADDR_LEVELS) begin
                levels_q <= regReq.wdata & LEVELS_MASK;
            end else if (regReq.addr == ADDR_REPEAT) begin
                repeat_q <= regReq.wdata;
            end
        end
    end

    // stored value is returned, never the sensed pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata <= 8'h00;
        end else if (regReq.read) begin
            if (regReq.addr == ADDR_DEBOUNCE) begin
                regRdata <= debounce_q;
            end else if (regReq.addr == ADDR_ALERT) begin
                regRdata <= alert_q;
            end else if (regReq.addr == ADDR_LEVELS) begin
                regRdata <= levels_q;
            end else if (regReq.addr == ADDR_REPEAT) begin
                regRdata <= repeat_q;
            end else begin
                regRdata <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timebase
    kpc_tick_gen #(
        .MS_COUNT     (MS_COUNT)
    ) u_tick (
        .clk          (clk),
        .reset_n      (reset_n),
        .debounceCode (debounce_q[DEB_TIME_LSB +: 5]),
        .msTick       (),
        .debounceTick (debTick)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            debounceTick <= 1'b0;
            debounceCode <= RST_DEBOUNCE[4:0];
        end else begin
            debounceTick <= debTick;
            debounceCode <= debounce_q[DEB_TIME_LSB +: 5];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output ports: index 0..5 are ports 2..7
    logic [2:0] portSel;
    logic [5:0] gpoMask;
    assign portSel = debounce_q[DEB_PORTS_LSB +: 3];

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_port
            // code n enables ports 7 down to 8-n; 11x covers all six
            assign gpoMask[gi] = (portSel >= 3'(6 - gi));
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    portOutEn[gi]  <= 1'b0;
                    portOut[gi]    <= 1'b0;
                    portScanEn[gi] <= 1'b0;
                end else begin
                    // open drain: drive low for 0, release for 1 others ignored
                    portOutEn[gi]  <= gpoMask[gi] && !levels_q[gi + 2];
                    portOut[gi]    <= 1'b0;
                    portScanEn[gi] <= !gpoMask[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // alert pin
    logic       alertAsGpo;
    logic [4:0] timeField;
    logic [2:0] fifoField;
    logic [4:0] fifoLevel;
    logic [4:0] timeCnt_q;
    logic       timeArmed_q;
    logic       alertAct_q;
    logic       timeHit;
    logic       fifoHit;

    assign alertAsGpo = (alert_q == 8'h00);
    assign timeField  = alert_q[ALT_TIME_LSB +: 5];
    assign fifoField  = alert_q[ALT_FIFO_LSB +: 3];
    // twice the code; 111 waits for the full sixteen-entry fifo, not fourteen
    assign fifoLevel  = (fifoField == 3'd7) ? FIFO_TOP_LEVEL : {1'b0, fifoField, 1'b0};
    assign fifoHit    = (fifoField != 3'd0) && (keyStatus.fifoCount >= fifoLevel);
    assign timeHit    = (timeField != 5'd0) && timeArmed_q && debTick
                        && (timeCnt_q + 5'd1 >= timeField);

    // count debounce cycles from the key event
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timeCnt_q   <= '0;
            timeArmed_q <= 1'b0;
        end else if (keyStatus.keyEvent) begin
            timeCnt_q   <= '0;
            timeArmed_q <= (timeField != 5'd0);
        end else if (timeHit) begin
            timeArmed_q <= 1'b0;
        end else if (timeArmed_q && debTick) begin
            timeCnt_q <= timeCnt_q + 5'd1;
        end
    end

    // either trigger asserts; a new trigger beats a same-cycle release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alertAct_q <= 1'b0;
        end else if (timeHit || fifoHit) begin
            alertAct_q <= 1'b1;
        end else if (keyStatus.clearOnRead ? keyStatus.hostFifoRead : keyStatus.fifoEmpty) begin
            alertAct_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alertOut   <= 1'b0;
            alertOutEn <= 1'b0;
        end else begin
            alertOut <= 1'b0;
            if (alertAsGpo) begin
                alertOutEn <= !levels_q[LVL_ALERT_BIT];
            end else begin
                alertOutEn <= alertAct_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // autorepeat
    kpc_repeat_timer u_repeat (
        .clk          (clk),
        .reset_n      (reset_n),
        .repeatReg    (repeat_q),
        .debounceTick (debTick),
        .keyEvent     (keyStatus.keyEvent),
        .anyHeld      (keyStatus.anyHeld),
        .repeatPush   (repPush),
        .repeatActive (repActive)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            repeatPush   <= 1'b0;
            repeatCode   <= REPEAT_CODE;
            repeatActive <= 1'b0;
        end else begin
            repeatPush   <= repPush;
            repeatCode   <= REPEAT_CODE;
            repeatActive <= repActive;
        end
    end
endmodule : kpc_config_bank
`default_nettype wire

//--- rtl/kpc_pkg.sv
/*
 * shared constants and types for the key-matrix controller configuration bank.
 * assumes a 100 MHz core clock and an 8-bit register port driven by the serial slave.
 */
package kpc_pkg;
    localparam int unsigned     CLK_PERIOD_NS   = 10;
    localparam int unsigned     MS_NS           = 1000000;
    localparam int unsigned     MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned     DEB_BASE_MS     = 9;

    localparam logic [7:0]      ADDR_DEBOUNCE   = 8'h02;
    localparam logic [7:0]      ADDR_ALERT      = 8'h03;
    localparam logic [7:0]      ADDR_LEVELS     = 8'h04;
    localparam logic [7:0]      ADDR_REPEAT     = 8'h05;

    localparam logic [7:0]      RST_DEBOUNCE    = 8'hff;
    localparam logic [7:0]      RST_ALERT       = 8'h00;
    localparam logic [7:0]      RST_LEVELS      = 8'hfe;
    localparam logic [7:0]      RST_REPEAT      = 8'h00;
    localparam logic [7:0]      LEVELS_MASK     = 8'hfe;

    localparam int unsigned     DEB_TIME_LSB    = 0;
    localparam int unsigned     DEB_PORTS_LSB   = 5;
    localparam int unsigned     ALT_TIME_LSB    = 0;
    localparam int unsigned     ALT_FIFO_LSB    = 5;
    localparam int unsigned     LVL_ALERT_BIT   = 1;
    localparam int unsigned     REP_DELAY_LSB   = 0;
    localparam int unsigned     REP_RATE_LSB    = 4;
    localparam int unsigned     REP_ENABLE_BIT  = 7;
    localparam int unsigned     REP_DELAY_UNIT  = 8;
    localparam int unsigned     REP_RATE_UNIT   = 4;

    localparam logic [7:0]      REPEAT_CODE     = 8'h7e;
    localparam logic [4:0]      FIFO_TOP_LEVEL  = 5'h10;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } kpc_reg_req_type;

    typedef struct packed {
        logic       keyEvent;
        logic       keyRelease;
        logic       anyHeld;
        logic       fifoEmpty;
        logic [4:0] fifoCount;
        logic       hostFifoRead;
        logic       clearOnRead;
    } kpc_key_status_type;
endpackage : kpc_pkg

//--- rtl/kpc_repeat_timer.sv
/*
 * autorepeat timing: delay then interval, counted in debounce cycles.
 * assumes key events and the held flag come from the scan logic, one pulse per event.
 */
`timescale 1ns/1ps
`default_nettype none
module kpc_repeat_timer
    import kpc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] repeatReg,
    input  wire logic       debounceTick,
    input  wire logic       keyEvent,
    input  wire logic       anyHeld,
    output logic            repeatPush,
    output logic            repeatActive
);
    typedef enum logic [1:0] {
        RP_IDLE  = 2'b00,
        RP_DELAY = 2'b01,
        RP_RATE  = 2'b11
    } kpc_rep_state_type;

    kpc_rep_state_type state_q;
    logic [7:0]        count_q;
    logic [7:0]        delayCycles;
    logic [7:0]        rateCycles;
    logic              enabled;

    assign enabled     = repeatReg[REP_ENABLE_BIT];
    // (k+1)*8 cycles, 8..128
    assign delayCycles = 8'({4'd0, repeatReg[REP_DELAY_LSB +: 4]} + 8'd1) * 8'(REP_DELAY_UNIT);
    // (k+1)*4 cycles, 4..32
    assign rateCycles  = 8'({5'd0, repeatReg[REP_RATE_LSB +: 3]} + 8'd1) * 8'(REP_RATE_UNIT);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= RP_IDLE;
            count_q    <= '0;
            repeatPush <= 1'b0;
        end else begin
            repeatPush <= 1'b0;
            if (!enabled || !anyHeld) begin
                state_q <= RP_IDLE;
                count_q <= '0;
            end else if (keyEvent) begin
                // any new event, release included, restarts the delay
                state_q <= RP_DELAY;
                count_q <= '0;
            end else begin
                case (state_q)
                    RP_IDLE: begin
                        state_q <= RP_DELAY;
                        count_q <= '0;
                    end
                    RP_DELAY, RP_RATE: begin
                        if (debounceTick) begin
                            if (count_q + 8'd1 >= ((state_q == RP_DELAY) ? delayCycles
                                                                         : rateCycles)) begin
                                // a single code per interval whatever is held
                                repeatPush <= 1'b1;
                                state_q    <= RP_RATE;
                                count_q    <= '0;
                            end else begin
                                count_q <= count_q + 8'd1;
                            end
                        end
                    end
                    default: state_q <= RP_IDLE;
                endcase
            end
        end
    end

    // scan logic suppresses the held key's own code while this is high
    assign repeatActive = (state_q == RP_RATE);
endmodule : kpc_repeat_timer
`default_nettype wire

//--- rtl/kpc_tick_gen.sv
/*
 * millisecond tick and debounce-cycle tick generator.
 * assumes the debounce code is static between writes; a change does not restart the cycle, the running ms count carries on.
 */
`timescale 1ns/1ps
`default_nettype none
module kpc_tick_gen
    import kpc_pkg::*;
#(
    parameter int unsigned  MS_COUNT = MS_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [4:0] debounceCode,
    output logic            msTick,
    output logic            debounceTick
);
    logic [31:0] msCnt_q;
    logic [5:0]  msInCycle_q;
    logic [5:0]  cycleLength;

    // code 0 is 9 ms, each step one more ms
    assign cycleLength = 6'(DEB_BASE_MS) + {1'b0, debounceCode};

    // whole-ms tick from the core clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            msCnt_q <= '0;
            msTick  <= 1'b0;
        end else if (msCnt_q == 32'(MS_COUNT - 1)) begin
            msCnt_q <= '0;
            msTick  <= 1'b1;
        end else begin
            msCnt_q <= msCnt_q + 32'd1;
            msTick  <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            msInCycle_q  <= '0;
            debounceTick <= 1'b0;
        end else if (msTick && (msInCycle_q + 6'd1 >= cycleLength)) begin
            msInCycle_q  <= '0;
            debounceTick <= 1'b1;
        end else begin
            if (msTick) begin
                msInCycle_q <= msInCycle_q + 6'd1;
            end
            debounceTick <= 1'b0;
        end
    end
endmodule : kpc_tick_gen
`default_nettype wire

//--- testbench/kpc_config_bank_asserts.sv
/* port checker for the configuration bank.
   sees only the bank's ports; bound after endmodule. */
`timescale 1ns/1ps
`default_nettype none
module kpc_config_bank_asserts
    import kpc_pkg::*;
#(
    parameter int unsigned MS_COUNT = MS_CYCLES
) (
    input wire logic               clk,
    input wire logic               reset_n,
    input wire kpc_reg_req_type    regReq,
    input wire logic [7:0]         regRdata,
    input wire kpc_key_status_type keyStatus,
    input wire logic [5:0]         portOutEn,
    input wire logic [5:0]         portOut,
    input wire logic [5:0]         portScanEn,
    input wire logic               alertOut,
    input wire logic               alertOutEn,
    input wire logic               repeatPush,
    input wire logic [7:0]         repeatCode,
    input wire logic               repeatActive,
    input wire logic               debounceTick,
    input wire logic [4:0]         debounceCode
);
    logic [7:0] debQ, altQ, lvlQ, repQ, rdMux;
    // shadow registers, written at the same edge as the bank's own
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            debQ <= 8'hff;
            altQ <= 8'h00;
            lvlQ <= 8'hfe;
            repQ <= 8'h00;
        end else if (regReq.write) begin
            if (regReq.addr == 8'h02) debQ <= regReq.wdata;
            if (regReq.addr == 8'h03) altQ <= regReq.wdata;
            if (regReq.addr == 8'h04) lvlQ <= regReq.wdata & 8'hfe;
            if (regReq.addr == 8'h05) repQ <= regReq.wdata;
        end
    end
    always_comb begin
        case (regReq.addr)
            8'h02: rdMux = debQ;
            8'h03: rdMux = altQ;
            8'h04: rdMux = lvlQ;
            8'h05: rdMux = repQ;
            default: rdMux = 8'h00;
        endcase
    end
    function automatic logic [5:0] gpoMask(input logic [2:0] c);
        return (c[2] & c[1]) ? 6'h3f : 6'(6'h3f << (3'd6 - c));
    endfunction : gpoMask
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    property p_deb; debounceCode == $past(debQ[4:0]); endproperty
    a_deb: assert property (p_deb) else $error("debounce code mismatch");
    property p_scan; portScanEn == ~gpoMask($past(debQ[7:5])); endproperty
    a_scan: assert property (p_scan) else $error("scan enable mismatch");
    property p_oen;
        portOutEn == (gpoMask($past(debQ[7:5])) & ~$past(lvlQ[7:2]));
    endproperty
    a_oen: assert property (p_oen) else $error("port drive mismatch");
    property p_olvl; portOut == 6'h00 && !alertOut; endproperty
    a_olvl: assert property (p_olvl) else $error("drive level not low");
    property p_gpo;
        (altQ == 8'h00 && $stable(lvlQ[1])) [*3] |-> alertOutEn == !lvlQ[1];
    endproperty
    a_gpo: assert property (p_gpo) else $error("alert gpo mismatch");
    property p_fifo;
        (altQ[7:5] != 3'd0 && keyStatus.fifoCount >= ((altQ[7:5] == 3'd7) ? 5'h10
                                                      : {1'b0, altQ[7:5], 1'b0}))
        [*3] |-> alertOutEn;
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo alert missing");
    property p_rel;
        (altQ != 8'h00 && keyStatus.fifoEmpty && !keyStatus.clearOnRead
         && !debounceTick) [*5] |-> !alertOutEn;
    endproperty
    a_rel: assert property (p_rel) else $error("alert not released");
    property p_rd; regReq.read && !regReq.write |=> regRdata == $past(rdMux); endproperty
    a_rd: assert property (p_rd) else $error("read data mismatch");
    property p_pulse; repeatPush |=> !repeatPush && repeatCode == REPEAT_CODE; endproperty
    a_pulse: assert property (p_pulse) else $error("repeat push not single");
    property p_ren; repeatPush |-> $past(repQ[7], 2); endproperty
    a_ren: assert property (p_ren) else $error("repeat while disabled");
    property p_tick; debounceTick |=> !debounceTick [*8]; endproperty
    a_tick: assert property (p_tick) else $error("debounce tick too close");
endmodule : kpc_config_bank_asserts
bind kpc_config_bank kpc_config_bank_asserts #(.MS_COUNT(MS_COUNT)) u_chk (.*);
`default_nettype wire

//--- testbench/kpc_scan_model.sv
/* scan-side stand-in: key events, held-key count and fifo level.
   assumes one-cycle pulses for key press, release and host read. */
`timescale 1ns/1ps
`default_nettype none
module kpc_scan_model
    import kpc_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          reset_n,
    input  wire logic          keyDown,
    input  wire logic          keyUp,
    input  wire logic          hostRead,
    input  wire logic          clearMode,
    input  wire logic          repeatPush,
    output var kpc_key_status_type keyStatus
);
    logic [4:0] countQ;
    logic [3:0] heldQ;
    // each cycle with a press, release or repeat code takes one fifo slot
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            countQ <= 5'h00;
            heldQ  <= 4'h0;
        end else begin
            countQ <= countQ + 5'(keyDown | keyUp | repeatPush)
                      - 5'(hostRead && countQ != 5'h00);
            heldQ  <= heldQ + 4'(keyDown) - 4'(keyUp);
        end
    end
    assign keyStatus = '{keyDown | keyUp, keyUp, heldQ != 4'h0, countQ == 5'h00,
                         countQ, hostRead, clearMode};
endmodule : kpc_scan_model
`default_nettype wire

//--- testbench/tb_kpc_config_bank.sv
/* self-checking bench for the configuration bank.
   assumes the scan model on the key side and MS_COUNT of 4. */
`timescale 1ns/1ps
`default_nettype none
module tb_kpc_config_bank;
    import kpc_pkg::*;
    localparam int DEB = 9 * 4;  // debounce cycle at code 0, in clocks
    logic clk = 1'b0, reset_n = 1'b0;
    kpc_reg_req_type regReq = '0;
    kpc_key_status_type keyStatus;
    logic [7:0] regRdata, repeatCode;
    logic [5:0] portOutEn, portOut, portScanEn;
    logic alertOut, alertOutEn, repeatPush, repeatActive, debounceTick;
    logic [4:0] debounceCode;
    logic keyDown = 0, keyUp = 0, hostRead = 0, clearMode = 0;
    int badCount = 0, testsRun = 0, n;
    always #5 clk = ~clk;
    kpc_config_bank #(.MS_COUNT(4)) u_dut (.*);
    kpc_scan_model u_model (.*);
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chkRange(input int v, input int lo, input int hi);
        testsRun++;
        if (v < lo || v > hi) begin
            badCount++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask : chkRange
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk) regReq <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) regReq <= '0;
        #1 chk(regRdata, exp);
    endtask : rd
    task automatic pulse(input int k);
        @(posedge clk);
        keyDown <= (k == 0);
        keyUp <= (k == 1);
        hostRead <= (k == 2);
        @(posedge clk);
        {keyDown, keyUp, hostRead} <= 3'b000;
    endtask : pulse
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : cyc
    // counts clocks to the next push (sel 0), alert (sel 1) or debounce tick (sel 2)
    task automatic waitSig(input int sel, input int lim, output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while ((sel == 2 ? debounceTick : sel ? alertOutEn : repeatPush) !== 1'b1
                   && c < lim);
    endtask : waitSig
    ////////////////////////////////////////////////////////////////
    task automatic tReset;
        rd(8'h02, 8'hff);
        rd(8'h03, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'h04, 8'hfe);
        rd(8'h07, 8'h00);
        chk({portScanEn, alertOutEn, 1'b0}, 8'h00);
        chk({3'b000, debounceCode}, 8'h1f);
        // code 31 is a 40 ms debounce cycle, four clocks per ms here
        waitSig(2, 200, n);
        waitSig(2, 200, n);
        chkRange(n, 40 * 4, 40 * 4);
    endtask : tReset
    task automatic tGpo;
        logic [5:0] m;
        wr(8'h04, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(8'h02, {3'(c), 5'h00});
            m = (c >= 6) ? 6'h3f : 6'(6'h3f << (6 - c));
            cyc(3);
            chk({2'b00, portScanEn}, {2'b00, ~m});
            chk({portOutEn, portOut}, {m, 6'h00});
            chk({7'h00, alertOutEn}, 8'h01);
        end
        wr(8'h04, 8'h57);
        rd(8'h04, 8'h56);
        wr(8'h02, 8'h40);
        cyc(3);
        chk({2'b00, portOutEn}, 8'h20);
        chk({7'h00, alertOutEn}, 8'h00);
        wr(8'h02, 8'h00);
    endtask : tGpo
    task automatic tFifo;
        // top code needs sixteen events; fifteen must not trip it
        wr(8'h03, 8'he0);
        repeat (7) begin
            pulse(0);
            pulse(1);
        end
        pulse(0);
        cyc(3);
        chk({7'h00, alertOutEn}, 8'h00);
        pulse(1);
        cyc(3);
        chk({7'h00, alertOutEn}, 8'h01);
        repeat (16) pulse(2);
        cyc(4);
        chk({7'h00, alertOutEn}, 8'h00);
        wr(8'h03, 8'h40);
        repeat (3) pulse(0);
        cyc(5);
        chk({7'h00, alertOutEn}, 8'h00);
        pulse(1);
        cyc(3);
        chk({7'h00, alertOutEn}, 8'h01);
        repeat (3) pulse(2);
        cyc(3);
        chk({7'h00, alertOutEn}, 8'h01);
        pulse(2);
        cyc(4);
        chk({7'h00, alertOutEn}, 8'h00);
    endtask : tFifo
    task automatic tTimed;
        @(posedge clk) clearMode <= 1'b1;
        wr(8'h03, 8'h22);
        pulse(1);
        pulse(2);
        cyc(30);
        chk({7'h00, alertOutEn}, 8'h00);
        waitSig(1, 60, n);
        chkRange(n + 30, DEB, 2 * DEB + 4);
        pulse(2);
        cyc(3);
        chk({7'h00, alertOutEn}, 8'h00);
        pulse(0);
        pulse(0);
        cyc(3);
        chk({7'h00, alertOutEn}, 8'h01);
        @(posedge clk) clearMode <= 1'b0;
        wr(8'h03, 8'h00);
    endtask : tTimed
    task automatic tRepeat;
        wr(8'h05, 8'h80);
        pulse(0);
        waitSig(0, 400, n);
        chkRange(n, 7 * DEB, 8 * DEB + 4);
        chk(repeatCode, REPEAT_CODE);
        waitSig(0, 400, n);
        chkRange(n, 4 * DEB, 4 * DEB);
        chk({7'h00, repeatActive}, 8'h01);
        wr(8'h05, 8'h91);
        pulse(1);
        waitSig(0, 700, n);
        chkRange(n, 15 * DEB, 16 * DEB + 4);
        waitSig(0, 400, n);
        chkRange(n, 8 * DEB, 8 * DEB);
        repeat (2) pulse(1);
        waitSig(0, 400, n);
        chkRange(n, 400, 400);
        wr(8'h05, 8'h0f);
        pulse(0);
        waitSig(0, 600, n);
        chkRange(n, 600, 600);
    endtask : tRepeat
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : printVerdict
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        tReset();
        tGpo();
        tFifo();
        tTimed();
        tRepeat();
        printVerdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        printVerdict();
    end
endmodule : tb_kpc_config_bank
`default_nettype wire
